// *** verification/vpadv_mgmt_model.sv ***
// serial management master model for the advertisement bank
`timescale 1ns/1ns
`default_nettype none
module vpadv_mgmt_model (
    input wire logic mclk_i,
    output logic smi_wr_o,
    output logic smi_rd_o,
    output logic [4:0] smi_reg_o,
    output logic [15:0] smi_wdata_o
);
    initial begin
        {smi_wr_o, smi_rd_o, smi_reg_o, smi_wdata_o} = '0;
    end
    // one-cycle strobe; selector always sent as 00001b
    task automatic access(input logic wr, input logic [4:0] rn, input logic [15:0] wd);
        @(posedge mclk_i);
        smi_wr_o <= wr;
        smi_rd_o <= ~wr;
        smi_reg_o <= rn;
        smi_wdata_o <= {wd[15:5], 5'h01};
        @(posedge mclk_i);
        {smi_wr_o, smi_rd_o} <= 2'b00;
        smi_wdata_o <= ~smi_wdata_o; // released data must not linger
        #1;
    endtask : access
endmodule : vpadv_mgmt_model
`default_nettype wire

// *** verification/vpadv_regs_tb.sv ***
// self-checking bench for the virtual phy advertisement bank
`timescale 1ns/1ns
`default_nettype none
module vpadv_regs_tb;
    import vpadv_pkg::*;
    typedef struct packed {logic smi; logic [11:0] a; logic [31:0] wd; logic [31:0] exp;} vpadv_row_t;
    logic mclk_i = 1'b0, reset_i = 1'b1, strap = 1'b0, hwr = 1'b0, hrd = 1'b0, ee_load = 1'b0;
    logic smi_wr, smi_rd, strap_fc;
    logic [4:0] smi_reg;
    logic [11:0] haddr = '0;
    logic [31:0] hwd = '0, hrdata;
    logic [15:0] smi_wd, smi_rdata, ee_data = '0, advert;
    int n_errors = 0, cmp_count = 0, cycles = 0;
    // ordinary cases: write one word, then read the advertisement back on both views
    vpadv_row_t rows[5] = '{'{1'b0, VPADV_OFS_ADVERT, 32'hffff_ffe1, 32'h0000_0de1},
        '{1'b0, VPADV_OFS_PARTNER, 32'h0000_0001, 32'h0000_0de1}, '{1'b0, 12'h0100, 32'h0000_0001, 32'h0000_0de1},
        '{1'b1, {7'h00, VPADV_SMI_ADVERT}, 32'h0000_0421, 32'h0000_0421},
        '{1'b1, {7'h00, VPADV_SMI_PARTNER}, 32'h0000_0001, 32'h0000_0421}};
    vpadv_regs vpadv_regs_inst (.mclk_i(mclk_i), .reset_i(reset_i), .flow_ctrl_manual_pin_setting_i(strap),
        .host_wr_i(hwr), .host_rd_i(hrd), .host_addr_i(haddr), .host_wdata_i(hwd), .host_rdata_o(hrdata),
        .smi_wr_i(smi_wr), .smi_rd_i(smi_rd), .smi_reg_i(smi_reg), .smi_wdata_i(smi_wd), .smi_rdata_o(smi_rdata),
        .ee_load_i(ee_load), .ee_data_i(ee_data), .advert_o(advert), .strap_fc_o(strap_fc));
    vpadv_mgmt_model mgmt_inst (.mclk_i(mclk_i), .smi_wr_o(smi_wr), .smi_rd_o(smi_rd), .smi_reg_o(smi_reg),
        .smi_wdata_o(smi_wd));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic host(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk_i);
        {hwr, hrd, haddr, hwd} <= {wr, ~wr, a, wd};
        @(posedge mclk_i);
        {hwr, hrd} <= 2'b00;
        #1;
    endtask : host
    // reset with a given strap, then move the strap after it was captured
    task automatic do_reset(input logic s);
        @(posedge mclk_i);
        {reset_i, strap} <= {1'b1, s};
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        strap <= ~s; // pin moves after capture and must be ignored
        @(posedge mclk_i);
        #1 chk({31'h0, strap_fc}, {31'h0, s});
        chk({16'h0, advert}, s ? 32'h0000_01e1 : 32'h0000_05e1);
        $display("reset test with strap %0d done", s);
    endtask : do_reset
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        do_reset(1'b0);
        host(1'b0, VPADV_OFS_PARTNER, '0);
        chk(hrdata, 32'h0000_05e1);
        host(1'b0, 12'h0100, '0);
        chk(hrdata, 32'h0000_0000);
        mgmt_inst.access(1'b0, VPADV_SMI_PARTNER, '0);
        chk({16'h0, smi_rdata}, 32'h0000_05e1);
        mgmt_inst.access(1'b0, 5'h1f, '0);
        chk({16'h0, smi_rdata}, 32'h0000_0000);
        $display("read-only and unmapped read test done");
        foreach (rows[i]) begin
            if (rows[i].smi) mgmt_inst.access(1'b1, rows[i].a[4:0], rows[i].wd[15:0]);
            else host(1'b1, rows[i].a, rows[i].wd);
            host(1'b0, VPADV_OFS_ADVERT, '0);
            chk(hrdata, rows[i].exp);
            mgmt_inst.access(1'b0, VPADV_SMI_ADVERT, '0);
            chk({16'h0, smi_rdata}, rows[i].exp);
        end
        $display("row test done");
        @(posedge mclk_i);
        {ee_load, ee_data} <= {1'b1, 16'hffff};
        @(posedge mclk_i);
        {ee_load, ee_data} <= {1'b0, 16'h0000};
        #1 chk({16'h0, advert}, 32'h0000_0dff);
        $display("loader test done");
        // same-cycle writers: host beats management
        fork
            host(1'b1, VPADV_OFS_ADVERT, 32'h0000_0461);
            mgmt_inst.access(1'b1, VPADV_SMI_ADVERT, 16'h0de1);
        join
        chk({16'h0, advert}, 32'h0000_0461);
        // same-cycle writers: loader beats host
        fork
            host(1'b1, VPADV_OFS_ADVERT, 32'h0000_0de1);
            begin
                @(posedge mclk_i);
                {ee_load, ee_data} <= {1'b1, 16'h01e1};
                @(posedge mclk_i);
                {ee_load, ee_data} <= {1'b0, 16'h0000};
            end
        join
        chk({16'h0, advert}, 32'h0000_01e1);
        $display("priority test done");
        do_reset(1'b1);
        complete_run();
    end
endmodule : vpadv_regs_tb
`default_nettype wire

// *** verilog/vpadv_pkg.sv ***
// package of offsets, field positions and reset values for the virtual phy advertisement bank
package vpadv_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses on the host bus)
    // ------------------------------------------------------------
    localparam logic [11:0] VPADV_OFS_ADVERT = 12'h01d0;
    localparam logic [11:0] VPADV_OFS_PARTNER = 12'h01d4;
    // serial management register numbers
    localparam logic [4:0] VPADV_SMI_ADVERT = 5'h04;
    localparam logic [4:0] VPADV_SMI_PARTNER = 5'h05;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int VPADV_BIT_NEXT_PAGE = 15;
    localparam int VPADV_BIT_REMOTE_FAULT = 13;
    localparam int VPADV_BIT_ASYM_PAUSE = 11;
    localparam int VPADV_BIT_SYM_PAUSE = 10;
    localparam int VPADV_BIT_T4 = 9;
    localparam int VPADV_BIT_ABIL_HI = 8;
    localparam int VPADV_BIT_ABIL_LO = 5;
    localparam int VPADV_BIT_SEL_HI = 4;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [15:0] VPADV_WRITE_MASK = 16'h0dff;
    localparam logic ASYM_PAUSE_RST = 1'b0;
    localparam logic [3:0] VPADV_ABIL_RST = 4'hf;
    localparam logic [4:0] VPADV_SEL_RST = 5'h01;
    // emulated partner page: 100/10 full/half, symmetric pause only, 802.3 selector
    localparam logic [15:0] VPADV_PARTNER_VAL = 16'h05e1;
endpackage : vpadv_pkg

// *** verilog/vpadv_regs.sv ***
// advertisement register and emulated link-partner register of the virtual phy
`timescale 1ns/1ns
`default_nettype none
module vpadv_regs (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic flow_ctrl_manual_pin_setting_i,
    // host bus
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [11:0] host_addr_i,
    input wire logic [31:0] host_wdata_i,
    output logic [31:0] host_rdata_o,
    // serial management
    input wire logic smi_wr_i,
    input wire logic smi_rd_i,
    input wire logic [4:0] smi_reg_i,
    input wire logic [15:0] smi_wdata_i,
    output logic [15:0] smi_rdata_o,
    // eeprom loader
    input wire logic ee_load_i,
    input wire logic [15:0] ee_data_i,
    output logic [15:0] advert_o,
    output logic strap_fc_o
);
    import vpadv_pkg::*;

    typedef struct packed {
        logic rst_seen;
        logic strap;
        logic [15:0] adv;
        logic [31:0] hrd;
        logic [15:0] srd;
    } vpadv_state_t;

    vpadv_state_t st_q;
    vpadv_state_t st_d;
    logic [15:0] rst_val;
    logic [15:0] partner_val;
    logic adv_host_hit;
    logic adv_smi_hit;

    // ------------------------------------------------------------
    // reset image and partner value
    // ------------------------------------------------------------
    always_comb begin
        rst_val = 16'h0000;
        rst_val[VPADV_BIT_ASYM_PAUSE] = ASYM_PAUSE_RST;
        // pin read directly: the image is only taken on the capture cycle, avoids a loop through st_d
        rst_val[VPADV_BIT_SYM_PAUSE] = ~flow_ctrl_manual_pin_setting_i;
        rst_val[VPADV_BIT_ABIL_HI:VPADV_BIT_ABIL_LO] = VPADV_ABIL_RST;
        rst_val[VPADV_BIT_SEL_HI:0] = VPADV_SEL_RST;
        partner_val = VPADV_PARTNER_VAL;
    end

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // shared by the write path and the checks so both agree on a hit
    assign adv_host_hit = host_wr_i && (host_addr_i == VPADV_OFS_ADVERT);
    assign adv_smi_hit = smi_wr_i && (smi_reg_i == VPADV_SMI_ADVERT);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // strap caught on the first clock after release, not under reset
        st_d.rst_seen = 1'b1;
        if (!st_q.rst_seen) begin
            st_d.strap = flow_ctrl_manual_pin_setting_i;
        end
        if (!st_q.rst_seen) begin
            st_d.adv = rst_val;
        end else if (ee_load_i) begin
            // loader wins over software: it defines the post-reset image
            st_d.adv = ee_data_i & VPADV_WRITE_MASK;
        end else if (adv_host_hit) begin
            // mask pins next page, remote fault, t4 and reserved bits at zero
            st_d.adv = host_wdata_i[15:0] & VPADV_WRITE_MASK;
        end else if (adv_smi_hit) begin
            st_d.adv = smi_wdata_i & VPADV_WRITE_MASK;
        end
        // read data registered, upper half padding
        if (host_rd_i) begin
            case (host_addr_i)
                VPADV_OFS_ADVERT: st_d.hrd = {16'h0000, st_q.adv};
                VPADV_OFS_PARTNER: st_d.hrd = {16'h0000, partner_val};
                default: st_d.hrd = 32'h0000_0000;
            endcase
        end
        if (smi_rd_i) begin
            case (smi_reg_i)
                VPADV_SMI_ADVERT: st_d.srd = st_q.adv;
                VPADV_SMI_PARTNER: st_d.srd = partner_val;
                default: st_d.srd = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign host_rdata_o = st_q.hrd;
    assign smi_rdata_o = st_q.srd;
    assign advert_o = st_q.adv;
    assign strap_fc_o = st_q.strap;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_NEXT_PAGE_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_q.rst_seen |-> !advert_o[VPADV_BIT_NEXT_PAGE]) else $error("next page bit set");
    AST_REMOTE_FAULT_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
        !advert_o[VPADV_BIT_REMOTE_FAULT]) else $error("remote fault bit set");
    AST_T4_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
        !advert_o[VPADV_BIT_T4]) else $error("t4 bit set");
    AST_RO_IGNORED: assert property (@(posedge mclk_i) disable iff (reset_i)
        (advert_o & ~VPADV_WRITE_MASK) == 16'h0000) else $error("read-only bit written");
    AST_PAUSE_DEFAULT: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(st_q.rst_seen) |-> advert_o[VPADV_BIT_SYM_PAUSE] == !strap_fc_o) else $error("pause default wrong");
    AST_RESET_IMAGE: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(st_q.rst_seen) |-> advert_o[8:0] == 9'h1e1) else $error("reset image wrong");
    AST_STRAP_HELD: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_q.rst_seen && $past(st_q.rst_seen) |-> $stable(strap_fc_o)) else $error("strap changed");
    AST_EE_LOAD: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_q.rst_seen && ee_load_i |=> advert_o == ($past(ee_data_i) & VPADV_WRITE_MASK)) else $error("load lost");
    AST_HOST_PAD: assert property (@(posedge mclk_i) disable iff (reset_i)
        host_rdata_o[31:16] == 16'h0000) else $error("padding nonzero");
    AST_PARTNER_READ: assert property (@(posedge mclk_i) disable iff (reset_i)
        host_rd_i && host_addr_i == VPADV_OFS_PARTNER |=> host_rdata_o[15:0] == VPADV_PARTNER_VAL)
        else $error("partner value wrong");

    // ------------------------------------------------------------
    // write, read and hold checks
    // ------------------------------------------------------------
    // these follow the priority of the write path, so each write
    // kind is only checked in the cycles where it really lands

    // a host write lands masked on the next cycle
    AST_HOST_WRITE: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_q.rst_seen && !ee_load_i && adv_host_hit |=>
        {16'h0000, advert_o} == ($past(host_wdata_i) & {16'h0000, VPADV_WRITE_MASK})) else $error("host write lost");

    // a management write lands when nothing stronger is present
    AST_SMI_WRITE: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_q.rst_seen && !ee_load_i && !adv_host_hit && adv_smi_hit |=>
        advert_o == ($past(smi_wdata_i) & VPADV_WRITE_MASK)) else $error("management write lost");

    // with no writer the advertisement keeps its value
    AST_ADV_HOLD: assert property (@(posedge mclk_i) disable iff (reset_i)
        st_q.rst_seen && !ee_load_i && !adv_host_hit && !adv_smi_hit |=>
        $stable(advert_o)) else $error("advertisement changed without a write");

    // host read of the advertisement returns it with zero padding
    AST_HOST_READ_ADV: assert property (@(posedge mclk_i) disable iff (reset_i)
        host_rd_i && host_addr_i == VPADV_OFS_ADVERT |=>
        host_rdata_o == {16'h0000, $past(advert_o)}) else $error("host advertisement read wrong");

    // unmapped host reads return zero
    AST_HOST_UNMAPPED: assert property (@(posedge mclk_i) disable iff (reset_i)
        host_rd_i && host_addr_i != VPADV_OFS_ADVERT && host_addr_i != VPADV_OFS_PARTNER |=>
        host_rdata_o == 32'h0000_0000) else $error("unmapped host read not zero");

    // management read of the advertisement is the 16-bit value
    AST_SMI_READ_ADV: assert property (@(posedge mclk_i) disable iff (reset_i)
        smi_rd_i && smi_reg_i == VPADV_SMI_ADVERT |=>
        smi_rdata_o == $past(advert_o)) else $error("management advertisement read wrong");

    // management read of the partner register gives the emulated page
    AST_SMI_PARTNER: assert property (@(posedge mclk_i) disable iff (reset_i)
        smi_rd_i && smi_reg_i == VPADV_SMI_PARTNER |=>
        smi_rdata_o == VPADV_PARTNER_VAL) else $error("management partner read wrong");

    // host read data stands until the next read strobe
    AST_HOST_RD_HOLD: assert property (@(posedge mclk_i) disable iff (reset_i)
        !host_rd_i |=>
        $stable(host_rdata_o)) else $error("host read data moved");

    // management read data stands until the next read strobe
    AST_SMI_RD_HOLD: assert property (@(posedge mclk_i) disable iff (reset_i)
        !smi_rd_i |=>
        $stable(smi_rdata_o)) else $error("management read data moved");

    // selector comes out of reset as the 802.3 code
    AST_SELECTOR_RESET: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(st_q.rst_seen) |->
        advert_o[VPADV_BIT_SEL_HI:0] == VPADV_SEL_RST) else $error("selector reset wrong");

    // asymmetric pause comes out of reset cleared
    AST_ASYM_RESET: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(st_q.rst_seen) |->
        advert_o[VPADV_BIT_ASYM_PAUSE] == ASYM_PAUSE_RST) else $error("asymmetric pause reset wrong");

    // the strap is taken from the pin on the capture cycle
    AST_STRAP_CAPTURE: assert property (@(posedge mclk_i) disable iff (reset_i)
        !st_q.rst_seen |=>
        strap_fc_o == $past(flow_ctrl_manual_pin_setting_i)) else $error("strap not captured");
endmodule : vpadv_regs
`default_nettype wire
